// >>> rtl/nand_pkg.sv
package nand_pkg;
	localparam logic [7:0] CMD_READ_A        = 8'h00;
	localparam logic [7:0] CMD_COPYBACK      = 8'h8a;
	localparam logic [7:0] CMD_CB_CONFIRM    = 8'h10;
	localparam logic [7:0] CMD_ERASE_SETUP   = 8'h60;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_STATUS        = 8'h70;
	localparam logic [7:0] CMD_RESET         = 8'hff;
	localparam logic [7:0] CMD_READ_ID       = 8'h90;
	localparam logic [7:0] ID_ADDR           = 8'h00;

	localparam logic [4:0] REG_CTRL     = 5'h00;
	localparam logic [4:0] REG_SRC      = 5'h04;
	localparam logic [4:0] REG_DST      = 5'h08;
	localparam logic [4:0] REG_STATUS   = 5'h0c;
	localparam logic [4:0] REG_ID       = 5'h10;
	localparam logic [4:0] REG_CB_COUNT = 5'h14;

	localparam int CTRL_OP_MSB      = 2;
	localparam int CTRL_CONFIRM_BIT = 3;
	localparam int CTRL_WP_N_BIT    = 4;
	localparam int ADDR_A25_BIT     = 24;

	localparam logic [7:0] SR_RESERVED_MASK = 8'h3e;
	localparam logic [7:0] ERASE_LAST_MASK  = 8'h03;

	localparam int CLK_PERIOD_NS   = 10;
	localparam int STROBE_LOW_NS   = 25;
	localparam int STROBE_HIGH_NS  = 15;
	localparam int BUSY_GUARD_NS   = 100;
	localparam int BUSY_TIMEOUT_NS = 3000000;
	localparam int STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_GUARD_CYC  = (BUSY_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_TIMEOUT_CYC = (BUSY_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0, OP_COPYBACK = 3'h1, OP_ERASE = 3'h2,
		OP_RESET = 3'h3, OP_STATUS = 3'h4, OP_READ_ID = 3'h5
	} nand_op_e;

	typedef enum logic [2:0] {
		K_CMD = 3'h0, K_ADDR = 3'h1, K_READ = 3'h2, K_WAIT = 3'h3, K_SKIP = 3'h4
	} cycle_kind_e;

	typedef struct packed {
		cycle_kind_e kind;
		logic [7:0]  data;
		logic        last;
	} seq_step_s;

	typedef struct packed {
		logic        valid;
		cycle_kind_e kind;
		logic [7:0]  data;
	} cycle_req_s;

	typedef struct packed {
		logic       done;
		logic [7:0] data;
	} cycle_rsp_s;
endpackage

// >>> rtl/nand_bus_cycle.sv
`timescale 1ns/100ps
module nand_bus_cycle #(
	parameter int IO_W = 8
) (
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_n_i,
	input  nand_pkg::cycle_req_s      req_i,
	output nand_pkg::cycle_rsp_s      rsp_o,
	output logic                      cle_o,
	output logic                      ale_o,
	output logic                      we_n_o,
	output logic                      re_n_o,
	output logic [IO_W-1:0]           io_o,
	output logic                      io_oe_o,
	input  wire logic [IO_W-1:0]      io_i
);
	typedef enum logic [1:0] {
		BC_IDLE = 2'b00, BC_SETUP = 2'b01, BC_STROBE = 2'b11, BC_HOLD = 2'b10
	} bc_state_e;

	typedef struct packed {
		bc_state_e             state;
		logic [3:0]            cnt;
		nand_pkg::cycle_kind_e kind;
		logic                  cle;
		logic                  ale;
		logic                  we_n;
		logic                  re_n;
		logic [IO_W-1:0]       io;
		logic                  oe;
		logic                  done;
		logic [7:0]            rdata;
	} bc_s;

	localparam logic [3:0] LOW_CNT  = 4'(nand_pkg::STROBE_LOW_CYC - 1);
	localparam logic [3:0] HIGH_CNT = 4'(nand_pkg::STROBE_HIGH_CYC - 1);

	if (IO_W != 8 && IO_W != 16) begin : g_bad_width
		$error("nand_bus_cycle: IO_W must be 8 or 16");
	end
	if (nand_pkg::STROBE_LOW_CYC > 16 || nand_pkg::STROBE_HIGH_CYC > 16) begin : g_bad_cnt
		$error("nand_bus_cycle: strobe counts exceed counter");
	end

	bc_s q_reg;
	bc_s q_next;

	always_comb begin
		q_next = q_reg;
		q_next.done = 1'b0;
		unique case (q_reg.state)
		BC_IDLE: begin
			if (req_i.valid) begin
				q_next.kind = req_i.kind;
				q_next.cle = (req_i.kind == nand_pkg::K_CMD);
				q_next.ale = (req_i.kind == nand_pkg::K_ADDR);
				q_next.oe = (req_i.kind != nand_pkg::K_READ);
				// upper byte lines stay low on a wide bus
				q_next.io = IO_W'(req_i.data);
				q_next.state = BC_SETUP;
			end
		end
		BC_SETUP: begin
			// one cycle of latch setup ahead of the strobe edge
			q_next.state = BC_STROBE;
			q_next.cnt = LOW_CNT;
			if (q_reg.kind == nand_pkg::K_READ)
				q_next.re_n = 1'b0;
			else
				q_next.we_n = 1'b0;
		end
		BC_STROBE: begin
			if (q_reg.cnt == 4'h0) begin
				q_next.we_n = 1'b1;
				q_next.re_n = 1'b1;
				if (q_reg.kind == nand_pkg::K_READ)
					q_next.rdata = io_i[7:0];
				q_next.state = BC_HOLD;
				q_next.cnt = HIGH_CNT;
			end else begin
				q_next.cnt = q_reg.cnt - 4'h1;
			end
		end
		BC_HOLD: begin
			if (q_reg.cnt == 4'h0) begin
				q_next.cle = 1'b0;
				q_next.ale = 1'b0;
				q_next.oe = 1'b0;
				q_next.done = 1'b1;
				q_next.state = BC_IDLE;
			end else begin
				q_next.cnt = q_reg.cnt - 4'h1;
			end
		end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_reg <= '0;
			q_reg.we_n <= 1'b1;
			q_reg.re_n <= 1'b1;
		end else begin
			q_reg <= q_next;
		end
	end

	assign rsp_o.done = q_reg.done;
	assign rsp_o.data = q_reg.rdata;
	assign cle_o = q_reg.cle;
	assign ale_o = q_reg.ale;
	assign we_n_o = q_reg.we_n;
	assign re_n_o = q_reg.re_n;
	assign io_o = q_reg.io;
	assign io_oe_o = q_reg.oe;

	property p_strobe_width;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$fell(we_n_o) |-> (!we_n_o && (cle_o || ale_o))[*3] ##1 we_n_o;
	endproperty
	a_strobe_width: assert property (p_strobe_width)
		else $error("write strobe low width or latch wrong");
endmodule

// >>> rtl/nand_copyback_erase_status_ctrl.sv
`timescale 1ns/100ps
module nand_copyback_erase_status_ctrl #(
	parameter int IO_W             = 8,
	parameter int BUSY_TIMEOUT_CYC = nand_pkg::BUSY_TIMEOUT_CYC
) (
	input  wire logic             clk_sys_i,
	input  wire logic             rst_n_i,
	input  wire logic [4:0]       avs_address_i,
	input  wire logic             avs_read_i,
	input  wire logic             avs_write_i,
	input  wire logic [31:0]      avs_writedata_i,
	input  wire logic [3:0]       avs_byteenable_i,
	output logic [31:0]           avs_readdata_o,
	output logic                  avs_waitrequest_o,
	output logic                  nand_ce_n_o,
	output logic                  nand_cle_o,
	output logic                  nand_ale_o,
	output logic                  nand_we_n_o,
	output logic                  nand_re_n_o,
	output logic                  nand_wp_n_o,
	output logic [IO_W-1:0]       nand_io_o,
	output logic                  nand_io_oe_o,
	input  wire logic [IO_W-1:0]  nand_io_i,
	input  wire logic             nand_rb_i
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_ISSUE = 2'b01, ST_GUARD = 2'b11, ST_WAITRB = 2'b10
	} ctl_state_e;

	typedef struct packed {
		ctl_state_e           state;
		nand_pkg::nand_op_e   op;
		logic [3:0]           idx;
		logic                 sent;
		nand_pkg::cycle_req_s req;
		logic [23:0]          timer;
		logic                 ce_n;
		logic                 wait_req;
		logic [31:0]          rdata;
		logic [31:0]          src;
		logic [31:0]          dst;
		logic                 confirm;
		logic                 wp_n;
		logic [7:0]           status;
		logic [7:0]           man_id;
		logic [7:0]           dev_id;
		logic                 timeout;
		logic                 refused;
		logic [15:0]          cb_count;
	} ctl_s;

	if (BUSY_TIMEOUT_CYC < 1 || BUSY_TIMEOUT_CYC >= 2 ** 24) begin : g_bad_timeout
		$error("nand ctrl: BUSY_TIMEOUT_CYC out of range");
	end

	ctl_s                 q_reg;
	ctl_s                 q_next;
	nand_pkg::seq_step_s  step;
	nand_pkg::cycle_rsp_s bc_rsp;
	nand_pkg::nand_op_e   op_req;
	logic                 busy;

	function automatic nand_pkg::seq_step_s mk(input nand_pkg::cycle_kind_e k,
		input logic [7:0] d, input logic l);
		mk = '{kind: k, data: d, last: l};
	endfunction

	function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] n);
		byte_of = w[{n, 3'b000} +: 8];
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		be_merge = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b])
				be_merge[b*8 +: 8] = nw[b*8 +: 8];
		end
	endfunction

	// one table drives all five operations; a skip entry lets the optional
	// copy-back confirm vanish without a second sequence
	function automatic nand_pkg::seq_step_s seq_step(input nand_pkg::nand_op_e op,
		input logic [3:0] i, input logic [31:0] src, input logic [31:0] dst,
		input logic cf);
		seq_step = mk(nand_pkg::K_SKIP, 8'h00, 1'b1);
		unique case (op)
		nand_pkg::OP_COPYBACK: begin
			// read A is reissued each time since status mode may persist
			if (i == 4'h0)
				seq_step = mk(nand_pkg::K_CMD, nand_pkg::CMD_READ_A, 1'b0);
			else if (i <= 4'h4)
				seq_step = mk(nand_pkg::K_ADDR, byte_of(src, 2'(i - 4'h1)), 1'b0);
			else if (i == 4'h5)
				seq_step = mk(nand_pkg::K_WAIT, 8'h00, 1'b0);
			else if (i == 4'h6)
				seq_step = mk(nand_pkg::K_CMD, nand_pkg::CMD_COPYBACK, 1'b0);
			else if (i <= 4'ha)
				seq_step = mk(nand_pkg::K_ADDR, byte_of(dst, 2'(i - 4'h7)), 1'b0);
			else if (i == 4'hb)
				seq_step = cf ? mk(nand_pkg::K_CMD, nand_pkg::CMD_CB_CONFIRM, 1'b0)
					: mk(nand_pkg::K_SKIP, 8'h00, 1'b0);
			else if (i == 4'hc)
				seq_step = mk(nand_pkg::K_WAIT, 8'h00, 1'b0);
			else if (i == 4'hd)
				seq_step = mk(nand_pkg::K_CMD, nand_pkg::CMD_STATUS, 1'b0);
			else
				seq_step = mk(nand_pkg::K_READ, 8'h00, 1'b1);
		end
		nand_pkg::OP_ERASE: begin
			// column byte is omitted; top row byte keeps only its low lines
			if (i == 4'h0)
				seq_step = mk(nand_pkg::K_CMD, nand_pkg::CMD_ERASE_SETUP, 1'b0);
			else if (i <= 4'h2)
				seq_step = mk(nand_pkg::K_ADDR, byte_of(src, 2'(i)), 1'b0);
			else if (i == 4'h3)
				seq_step = mk(nand_pkg::K_ADDR,
					byte_of(src, 2'(i)) & nand_pkg::ERASE_LAST_MASK, 1'b0);
			else if (i == 4'h4)
				seq_step = mk(nand_pkg::K_CMD, nand_pkg::CMD_ERASE_CONFIRM, 1'b0);
			else if (i == 4'h5)
				seq_step = mk(nand_pkg::K_WAIT, 8'h00, 1'b0);
			else if (i == 4'h6)
				seq_step = mk(nand_pkg::K_CMD, nand_pkg::CMD_STATUS, 1'b0);
			else
				seq_step = mk(nand_pkg::K_READ, 8'h00, 1'b1);
		end
		nand_pkg::OP_RESET: begin
			if (i == 4'h0)
				seq_step = mk(nand_pkg::K_CMD, nand_pkg::CMD_RESET, 1'b0);
			else if (i == 4'h1)
				seq_step = mk(nand_pkg::K_WAIT, 8'h00, 1'b0);
			else if (i == 4'h2)
				seq_step = mk(nand_pkg::K_CMD, nand_pkg::CMD_STATUS, 1'b0);
			else
				seq_step = mk(nand_pkg::K_READ, 8'h00, 1'b1);
		end
		nand_pkg::OP_STATUS: begin
			if (i == 4'h0)
				seq_step = mk(nand_pkg::K_CMD, nand_pkg::CMD_STATUS, 1'b0);
			else
				seq_step = mk(nand_pkg::K_READ, 8'h00, 1'b1);
		end
		nand_pkg::OP_READ_ID: begin
			if (i == 4'h0)
				seq_step = mk(nand_pkg::K_CMD, nand_pkg::CMD_READ_ID, 1'b0);
			else if (i == 4'h1)
				seq_step = mk(nand_pkg::K_ADDR, nand_pkg::ID_ADDR, 1'b0);
			else
				seq_step = mk(nand_pkg::K_READ, 8'h00, i == 4'h3);
		end
		default: seq_step = mk(nand_pkg::K_SKIP, 8'h00, 1'b1);
		endcase
	endfunction

	assign step = seq_step(q_reg.op, q_reg.idx, q_reg.src, q_reg.dst, q_reg.confirm);
	assign busy = (q_reg.state != ST_IDLE);
	assign op_req = nand_pkg::nand_op_e'(avs_writedata_i[nand_pkg::CTRL_OP_MSB:0]);

	always_comb begin
		q_next = q_reg;
		q_next.req.valid = 1'b0;
		q_next.wait_req = 1'b1;

		// one-cycle answer: waitrequest drops for exactly one cycle
		if ((avs_read_i || avs_write_i) && q_reg.wait_req) begin
			q_next.wait_req = 1'b0;
			case (avs_address_i)
			nand_pkg::REG_CTRL:
				q_next.rdata = {27'h0, q_reg.wp_n, q_reg.confirm, q_reg.op};
			nand_pkg::REG_SRC:
				q_next.rdata = q_reg.src;
			nand_pkg::REG_DST:
				q_next.rdata = q_reg.dst;
			nand_pkg::REG_STATUS:
				q_next.rdata = {21'h0, q_reg.refused, q_reg.timeout, busy, q_reg.status};
			nand_pkg::REG_ID:
				q_next.rdata = {16'h0, q_reg.dev_id, q_reg.man_id};
			nand_pkg::REG_CB_COUNT:
				q_next.rdata = {16'h0, q_reg.cb_count};
			default:
				q_next.rdata = 32'h0;
			endcase
		end

		if (avs_write_i && !q_reg.wait_req) begin
			case (avs_address_i)
			nand_pkg::REG_CTRL: begin
				if (avs_byteenable_i[0]) begin
					q_next.confirm = avs_writedata_i[nand_pkg::CTRL_CONFIRM_BIT];
					q_next.wp_n = avs_writedata_i[nand_pkg::CTRL_WP_N_BIT];
					if (op_req != nand_pkg::OP_NONE) begin
						if (busy || op_req > nand_pkg::OP_READ_ID
							|| (op_req == nand_pkg::OP_COPYBACK
							&& q_reg.src[nand_pkg::ADDR_A25_BIT]
							!= q_reg.dst[nand_pkg::ADDR_A25_BIT])) begin
							q_next.refused = 1'b1;
						end else begin
							q_next.op = op_req;
							q_next.idx = 4'h0;
							q_next.sent = 1'b0;
							q_next.state = ST_ISSUE;
							q_next.ce_n = 1'b0;
							q_next.timeout = 1'b0;
							q_next.refused = 1'b0;
							// no ECC covers a copy-back, so software gets a tally
							if (op_req == nand_pkg::OP_COPYBACK)
								q_next.cb_count = q_reg.cb_count + 16'h1;
						end
					end
				end
			end
			nand_pkg::REG_SRC: begin
				if (!busy)
					q_next.src = be_merge(q_reg.src, avs_writedata_i, avs_byteenable_i);
			end
			nand_pkg::REG_DST: begin
				if (!busy)
					q_next.dst = be_merge(q_reg.dst, avs_writedata_i, avs_byteenable_i);
			end
			default: begin
			end
			endcase
		end

		// no program path exists, so a copy-back target never sees a partial program
		unique case (q_reg.state)
		ST_IDLE: begin
		end
		ST_ISSUE: begin
			if (!q_reg.sent) begin
				unique case (step.kind)
				nand_pkg::K_WAIT: begin
					q_next.state = ST_GUARD;
					q_next.timer = 24'(nand_pkg::BUSY_GUARD_CYC - 1);
				end
				nand_pkg::K_SKIP: begin
					if (step.last) begin
						q_next.state = ST_IDLE;
						q_next.ce_n = 1'b1;
					end else begin
						q_next.idx = q_reg.idx + 4'h1;
					end
				end
				nand_pkg::K_CMD, nand_pkg::K_ADDR, nand_pkg::K_READ: begin
					q_next.req = '{valid: 1'b1, kind: step.kind, data: step.data};
					q_next.sent = 1'b1;
				end
				endcase
			end else if (bc_rsp.done) begin
				if (step.kind == nand_pkg::K_READ) begin
					if (q_reg.op == nand_pkg::OP_READ_ID) begin
						if (q_reg.idx == 4'h2)
							q_next.man_id = bc_rsp.data;
						else
							q_next.dev_id = bc_rsp.data;
					end else begin
						q_next.status = bc_rsp.data & ~nand_pkg::SR_RESERVED_MASK;
					end
				end
				q_next.sent = 1'b0;
				if (step.last) begin
					q_next.state = ST_IDLE;
					q_next.ce_n = 1'b1;
				end else begin
					q_next.idx = q_reg.idx + 4'h1;
				end
			end
		end
		ST_GUARD: begin
			// ready may still read high until the device has had time to drop it
			if (q_reg.timer == 24'h0) begin
				q_next.state = ST_WAITRB;
				q_next.timer = 24'(BUSY_TIMEOUT_CYC - 1);
			end else begin
				q_next.timer = q_reg.timer - 24'h1;
			end
		end
		ST_WAITRB: begin
			if (nand_rb_i) begin
				q_next.idx = q_reg.idx + 4'h1;
				q_next.state = ST_ISSUE;
			end else if (q_reg.timer == 24'h0) begin
				q_next.timeout = 1'b1;
				q_next.state = ST_IDLE;
				q_next.ce_n = 1'b1;
			end else begin
				q_next.timer = q_reg.timer - 24'h1;
			end
		end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_reg <= '0;
			q_reg.ce_n <= 1'b1;
			q_reg.wait_req <= 1'b1;
		end else begin
			q_reg <= q_next;
		end
	end

	nand_bus_cycle #(
		.IO_W (IO_W)
	) u_bus_cycle (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.req_i     (q_reg.req),
		.rsp_o     (bc_rsp),
		.cle_o     (nand_cle_o),
		.ale_o     (nand_ale_o),
		.we_n_o    (nand_we_n_o),
		.re_n_o    (nand_re_n_o),
		.io_o      (nand_io_o),
		.io_oe_o   (nand_io_oe_o),
		.io_i      (nand_io_i)
	);

	assign avs_readdata_o = q_reg.rdata;
	assign avs_waitrequest_o = q_reg.wait_req;
	assign nand_ce_n_o = q_reg.ce_n;
	assign nand_wp_n_o = q_reg.wp_n;

	property p_cb_waits_ready;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(q_reg.state == ST_WAITRB && q_reg.op == nand_pkg::OP_COPYBACK
			&& q_reg.idx == 4'h5 && nand_rb_i)
		|-> ##2 (q_reg.req.valid && q_reg.req.data == nand_pkg::CMD_COPYBACK);
	endproperty
	a_cb_waits_ready: assert property (p_cb_waits_ready)
		else $error("copy-back second command not issued after ready");

	property p_a25_kept;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		($rose(busy) && q_reg.op == nand_pkg::OP_COPYBACK)
		|-> q_reg.src[nand_pkg::ADDR_A25_BIT] == q_reg.dst[nand_pkg::ADDR_A25_BIT];
	endproperty
	a_a25_kept: assert property (p_a25_kept)
		else $error("copy-back started with differing A25");

	property p_cb_addr_cycles;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(q_reg.req.valid && q_reg.op == nand_pkg::OP_COPYBACK
			&& q_reg.req.kind == nand_pkg::K_ADDR)
		|-> q_reg.idx inside {[4'h1:4'h4], [4'h7:4'ha]};
	endproperty
	a_cb_addr_cycles: assert property (p_cb_addr_cycles)
		else $error("copy-back address cycle out of place");

	property p_erase_addr;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(q_reg.req.valid && q_reg.op == nand_pkg::OP_ERASE
			&& q_reg.req.kind == nand_pkg::K_ADDR)
		|-> q_reg.idx inside {[4'h1:4'h3]};
	endproperty
	a_erase_addr: assert property (p_erase_addr)
		else $error("erase sent more than three address cycles");

	property p_erase_last_low;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(q_reg.req.valid && q_reg.op == nand_pkg::OP_ERASE && q_reg.idx == 4'h3)
		|-> (q_reg.req.data & ~nand_pkg::ERASE_LAST_MASK) == 8'h00;
	endproperty
	a_erase_last_low: assert property (p_erase_last_low)
		else $error("erase last address has high lines set");

	property p_erase_confirm;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(q_reg.req.valid && q_reg.op == nand_pkg::OP_ERASE && q_reg.idx == 4'h4)
		|-> (q_reg.req.kind == nand_pkg::K_CMD
			&& q_reg.req.data == nand_pkg::CMD_ERASE_CONFIRM);
	endproperty
	a_erase_confirm: assert property (p_erase_confirm)
		else $error("erase confirm code wrong");

	property p_erase_status;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(bc_rsp.done && q_reg.state == ST_ISSUE && q_reg.op == nand_pkg::OP_ERASE
			&& q_reg.idx == 4'h7)
		|=> (q_reg.status == ($past(bc_rsp.data) & ~nand_pkg::SR_RESERVED_MASK)
			&& q_reg.state == ST_IDLE && q_reg.ce_n);
	endproperty
	a_erase_status: assert property (p_erase_status)
		else $error("erase status not captured at completion");

	property p_status_reserved;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$changed(q_reg.status) |-> (q_reg.status & nand_pkg::SR_RESERVED_MASK) == 8'h00;
	endproperty
	a_status_reserved: assert property (p_status_reserved)
		else $error("reserved status bits kept");

	property p_id_address;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(q_reg.req.valid && q_reg.op == nand_pkg::OP_READ_ID
			&& q_reg.req.kind == nand_pkg::K_ADDR)
		|-> (q_reg.req.data == nand_pkg::ID_ADDR && q_reg.idx == 4'h1);
	endproperty
	a_id_address: assert property (p_id_address)
		else $error("identification address wrong");

	c_erase_done: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$fell(busy) && q_reg.op == nand_pkg::OP_ERASE && !q_reg.timeout);
	c_cb_confirm: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		q_reg.req.valid && q_reg.req.data == nand_pkg::CMD_CB_CONFIRM);
	c_id_done: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$fell(busy) && q_reg.op == nand_pkg::OP_READ_ID);
	c_timeout: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$rose(q_reg.timeout));
endmodule

// >>> sim/nand_dev_model.sv
`timescale 1ns/100ps
module nand_dev_model #(
	parameter logic [7:0] MFR_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0] DEV_CODE = 8'ha5  // arbitrary value
) (
	input  wire logic       ce_n_i,
	input  wire logic       cle_i,
	input  wire logic       ale_i,
	input  wire logic       we_n_i,
	input  wire logic       re_n_i,
	input  wire logic       wp_n_i,
	input  wire logic       fail_i,
	input  wire logic       oe_i,
	input  wire logic [7:0] io_i,
	output logic      [7:0] io_o,
	output logic            rb_o,
	output logic            proto_err_o
);
	logic [7:0] cmd = 8'h00;
	logic [7:0] last = 8'h00;
	logic [7:0] val;
	logic       err = 1'b0;
	logic       a25 = 1'b0;
	logic       fresh = 1'b1;
	int         na = 0;
	int         nr = 0;
	initial rb_o = 1'b1;
	initial proto_err_o = 1'b0;
	// overlapping busy windows are not merged; the bench never overlaps them
	task automatic go(input int t);
		rb_o = 1'b0;
		fork
			#t rb_o = 1'b1;
		join_none
	endtask
	always @(posedge we_n_i) begin
		// a strobed cycle on undriven lines would latch garbage
		if (!ce_n_i && !oe_i) proto_err_o = 1'b1;
		if (!ce_n_i && cle_i && (rb_o || io_i == 8'h70 || io_i == 8'hff)) begin
			if (io_i == 8'hff && !fresh) begin
				err = 1'b0;
				go(300);
			end
			if (io_i == 8'hd0 && cmd == 8'h60) begin
				if (na != 3 || last[7:2] != 6'h00) proto_err_o = 1'b1;
				err = fail_i;
				go(400);
			end
			fresh = (io_i == 8'hff);
			cmd = io_i;
			na = 0;
			nr = 0;
		end else if (!ce_n_i && ale_i) begin
			if (!rb_o || (cmd == 8'h90 && io_i != 8'h00)) proto_err_o = 1'b1;
			na++;
			last = io_i;
			if (na == 4 && cmd == 8'h00) begin
				a25 = io_i[0];
				go(400);
			end
			if (na == 4 && cmd == 8'h8a) begin
				if (io_i[0] != a25) proto_err_o = 1'b1;
				err = fail_i;
				go(400);
			end
		end
	end
	always @(negedge re_n_i) begin
		// controller still driving while the device answers means contention
		if (!ce_n_i && oe_i) proto_err_o = 1'b1;
		if (!ce_n_i) nr++;
	end
	// reserved status bits are driven non-zero on purpose
	always @* begin
		if (cmd == 8'h70) val = {wp_n_i, rb_o, 5'h15, err};
		else if (cmd == 8'h90 && nr == 1) val = MFR_CODE;
		else if (cmd == 8'h90 && nr == 2) val = DEV_CODE;
		else val = 8'hff; // erased cells read as ones
		// x8 part: there are no upper byte lines to clear
		io_o = (ce_n_i || re_n_i) ? ~val : val;
	end
endmodule

// >>> sim/nand_copyback_erase_status_ctrl_tb.sv
`timescale 1ns/100ps
module nand_copyback_erase_status_ctrl_tb;
	logic        clk_sys_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic        fail = 1'b0;
	logic        stall = 1'b0;
	logic        oe;
	logic [4:0]  addr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] q;
	logic        wait_req, ce_n, cle, ale, we_n, re_n, wp_n, rb, perr;
	logic [7:0]  io_out, io_in;
	int          n_errors = 0;
	int          samples_checked = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	nand_copyback_erase_status_ctrl #(.IO_W(8), .BUSY_TIMEOUT_CYC(200))
	i_nand_copyback_erase_status_ctrl (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
		.nand_ce_n_o(ce_n), .nand_cle_o(cle), .nand_ale_o(ale), .nand_we_n_o(we_n),
		.nand_re_n_o(re_n), .nand_wp_n_o(wp_n), .nand_io_o(io_out), .nand_io_oe_o(oe),
		.nand_io_i(io_in), .nand_rb_i(rb && !stall));
	nand_dev_model i_nand_dev_model (.ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
		.re_n_i(re_n), .wp_n_i(wp_n), .fail_i(fail), .oe_i(oe), .io_i(io_out), .io_o(io_in),
		.rb_o(rb), .proto_err_o(perr));
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys_i);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		for (i = 0; i < 20 && wait_req !== 1'b0; i++) @(posedge clk_sys_i);
		if (i == 20) n_errors++;
		if (i == 20) test_done();
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	// polls until the sequencer reports idle; q holds the final status word
	task automatic op(input logic [31:0] ctrl);
		int i;
		bus(1'b1, nand_pkg::REG_CTRL, ctrl);
		for (i = 0; i < 400; i++) begin
			bus(1'b0, nand_pkg::REG_STATUS, 32'h0);
			if (q[8] === 1'b0) break;
		end
		if (i == 400) n_errors++;
		if (i == 400) test_done();
		$display("operation %h finished", ctrl);
	endtask
	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		bus(1'b0, 5'h18, 32'h0);
		chk(q, 32'h0, "unmapped");
		op(32'h05);
		bus(1'b0, nand_pkg::REG_ID, 32'h0);
		chk(q[15:0], 16'ha55a, "ident");
		op(32'h04);
		chk(q[10:0], 11'h040, "status protected");
		op(32'h14);
		chk(q[10:0], 11'h0c0, "status open");
		fail <= 1'b1;
		bus(1'b1, nand_pkg::REG_SRC, 32'hff123456);
		op(32'h12);
		chk(q[10:0], 11'h0c1, "erase fail");
		op(32'h13);
		chk(q[10:0], 11'h0c0, "after reset");
		// ready held low past the limit: the op must give up and flag it
		stall <= 1'b1;
		op(32'h13);
		chk(q[10:8], 3'b010, "busy timeout");
		stall <= 1'b0;
		bus(1'b1, nand_pkg::REG_SRC, 32'h01aa5500);
		bus(1'b1, nand_pkg::REG_DST, 32'h01010200);
		op(32'h19);
		chk(q[10:0], 11'h0c1, "copy fail");
		fail <= 1'b0;
		op(32'h11);
		chk(q[10:0], 11'h0c0, "copy ok");
		bus(1'b1, nand_pkg::REG_DST, 32'h00010200);
		op(32'h11);
		chk(q[10:0], 11'h4c0, "copy refused");
		bus(1'b0, nand_pkg::REG_CB_COUNT, 32'h0);
		chk(q[15:0], 16'h0002, "copy count");
		chk({31'h0, perr}, 32'h0, "wire protocol");
		test_done();
	end
endmodule
